/* core/pimc_pkg.sv */
// Constants and types for the peripheral interrupt and mode control block
package pimc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_PIO_EN_LO = 16'h2006;
    localparam logic [15:0] IDX_PIO_FLG_LO = 16'h2007;
    localparam logic [15:0] IDX_MODE = 16'h2015;
    localparam logic [15:0] IDX_SYSTEM_STATUS = 16'h2016;
    localparam logic [15:0] IDX_TSF = 16'h2017;
    localparam logic [15:0] IDX_PIO_EN_HI = 16'h2046;
    localparam logic [15:0] IDX_PIO_FLG_HI = 16'h2047;
    localparam logic [15:0] IDX_SWTRIP = 16'h2061;
    localparam logic [15:0] IDX_SYSCTL = 16'h3FFF;
    localparam logic [15:0] IDX_IFC = 16'h2100;
    localparam logic [15:0] IDX_ICTL = 16'h2101;
    localparam logic [15:0] IDX_CORE_INTERRUPT_MASK = 16'h2102;
    localparam logic [15:0] IDX_IPEND = 16'h2103;
    // Field positions
    localparam int ICTL_RX_EDGE = 0;
    localparam int ICTL_TX_EDGE = 1;
    localparam int ICTL_PER_EDGE = 2;
    localparam int ICTL_NEST = 4;
    localparam int MODE_RXSEL = 4;
    localparam int MODE_UART = 5;
    localparam int SYSCTL_ALT = 10;
    localparam int IFC_FORCE = 8;
    localparam int TSF_TRIP = 0;
    localparam int TSF_SYNC = 1;
    // Core interrupt indices, higher index wins
    localparam int CI_TIMER = 0;
    localparam int CI_RX = 1;
    localparam int CI_TX = 2;
    localparam int CI_PER = 7;
    // Mask bit position of each core interrupt
    localparam logic [7:0][3:0] MASK_POS = {4'h9, 4'h8, 4'h7, 4'h1, 4'h2, 4'h4, 4'h3, 4'h0};
    // Vector word addresses per core interrupt
    localparam logic [7:0][5:0] VEC = {6'h04, 6'h14, 6'h10, 6'h18, 6'h1C, 6'h20, 6'h24, 6'h28};
    localparam logic [5:0] VEC_TRIP = 6'h2C;
    localparam logic [5:0] VEC_SYNC = 6'h0C;
    localparam logic [5:0] VEC_PIO = 6'h08;
    // Reset values
    localparam logic [15:0] RST_16 = 16'h0000;
    localparam logic [8:0] RST_9 = 9'h000;
    localparam logic [7:0] RST_8 = 8'h00;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [17:0] adr;
        logic [31:0] dat;
    } pimc_wb_req_t;
endpackage

/* core/pimc_top.sv */
// Peripheral interrupt collection, core interrupt control and serial pin mux
// Function
// (RULE1) Force/clear register: low byte clears, high forces
// (RULE2) Software interrupts only from force bits 11,12
// (RULE3) Control bit 0: receive interrupt edge or level
// (RULE4) Bits 1,2: transmit and peripheral sensitivity
// (RULE5) Software keeps peripheral interrupt level sensitive
// (RULE6) Nesting allowed only while control bit 4 set
// (RULE7) Four-word vector slots within words 0x00-0x2F
// (RULE8) Unmasked core interrupt dispatches without extra delay
// (RULE9) Peripheral events set flags, hold line low
// (RULE10) Highest priority pending source served first
// (RULE11) Reading trip/sync status clears and acknowledges
// (RULE12) Reading either pin flag register clears both
// (RULE13) Any reset kind restores peripheral registers
// (RULE14) System status shows trip, watchdog, timer
// (RULE15) Mode bit 4 picks second receive pin
// (RULE16) Mode bit 5 ties receive data, frame sync
// (RULE17) UART mode drives frame-sync pin from flag
// (RULE18) Control bit 10: receive flag in, transmit flag out
// (RULE19) Alternate mode: frame-sync pins become interrupts
// (RULE20) Trip from pin fall, overcurrent, software write
// (RULE21) Sync interrupt on rising sync pulse edge
// (RULE22) Software enables mask bit 9 for peripherals
// (RULE23) Event during clearing read stays pending
module pimc_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sw_reset_i,
    input wire logic wdog_reset_i,
    // Wishbone slave
    input wire pimc_pkg::pimc_wb_req_t wb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Sequencer side
    input wire logic timer_irq_i,
    input wire logic sport_rx_irq_i,
    input wire logic sport_tx_irq_i,
    input wire logic irq_take_i,
    input wire logic irq_return_i,
    output logic irq_req_o,
    output logic [5:0] irq_vector_o,
    // Motor-control peripheral events
    input wire logic trip_input_n_i,
    input wire logic overcurrent_i,
    input wire logic pwm_sync_pulse_i,
    input wire logic [8:0] pio_pins_i,
    input wire logic wdog_state_i,
    input wire logic [1:0] pwm_state_i,
    output logic peripheral_interrupt_line_n_o,
    // Serial port pins and internal side
    input wire logic receive_pin_first_i,
    input wire logic receive_pin_second_i,
    input wire logic receive_frame_sync_i,
    input wire logic transmit_frame_sync_i,
    input wire logic sport_dt_i,
    input wire logic sport_rfs_o_i,
    input wire logic sport_rfs_oe_i,
    input wire logic core_output_flag_i,
    input wire logic flag_output_pin_i,
    output logic internal_receive_input_o,
    output logic internal_rfs_o,
    output logic flag_input_pin_o,
    output logic transmit_data_pin_o,
    output logic receive_frame_sync_o,
    output logic receive_frame_sync_oe_o
);
    import pimc_pkg::*;

    // Any reset kind clears the peripheral registers; the bus acknowledge resets on rst_i only (see RULE13)
    wire rst_all = rst_i | sw_reset_i | wdog_reset_i;

    // Pin synchronisers
    logic [14:0] s1_q, s2_q;
    always_ff @(posedge clk_i) begin
        s1_q <= {overcurrent_i, trip_input_n_i, transmit_frame_sync_i,
                 receive_frame_sync_i, receive_pin_second_i, receive_pin_first_i, pio_pins_i};
        s2_q <= s1_q;
    end
    wire [8:0] pio_s = s2_q[8:0];
    wire rxa_s = s2_q[9];
    wire rxb_s = s2_q[10];
    wire rfs_s = s2_q[11];
    wire tfs_s = s2_q[12];
    wire trip_n_s = s2_q[13];
    wire oc_s = s2_q[14];

    // Registers
    logic [8:0] mode_q, pio_en_q, pio_flg_q, pio_prev_q;
    logic [15:0] sysctl_q, core_interrupt_mask_q;
    logic [4:0] ictl_q;
    logic [1:0] tsf_q;
    logic [7:0] lat_q, isv_q;
    logic [2:0] edge_prev_q;
    logic trip_prev_q, oc_prev_q, sync_prev_q, ack_q;
    logic [31:0] rdat_q;

    // Bus decode
    wire req = wb_i.cyc & wb_i.stb & ~ack_q;
    wire [15:0] idx = wb_i.adr[17:2];
    wire wr = req & wb_i.we;
    wire rd = req & ~wb_i.we;
    wire [15:0] wdat = wb_i.dat[15:0];
    wire [1:0] lane = wb_i.sel[1:0];
    wire wr_ifc = wr && idx == IDX_IFC && lane == 2'b11;
    wire rd_tsf = rd && idx == IDX_TSF;
    wire rd_pio = rd && (idx == IDX_PIO_FLG_LO || idx == IDX_PIO_FLG_HI);
    wire wr_swt = wr && idx == IDX_SWTRIP && lane[0] && wdat[0];
    wire [15:0] bmask = {{8{lane[1]}}, {8{lane[0]}}};

    // Peripheral event detection (see RULE20) (see RULE21)
    wire trip_ev = (trip_prev_q & ~trip_n_s) | (oc_s & ~oc_prev_q) | wr_swt;
    wire sync_ev = pwm_sync_pulse_i & ~sync_prev_q;
    wire [8:0] pio_ev = (pio_s ^ pio_prev_q) & pio_en_q;

    // Alternate serial configuration (see RULE18) (see RULE19)
    wire alt = sysctl_q[SYSCTL_ALT];
    wire uart = mode_q[MODE_UART];
    wire rx_sel = mode_q[MODE_RXSEL] ? rxb_s : rxa_s;
    wire rx_lvl = alt ? ~rfs_s : sport_rx_irq_i;
    wire tx_lvl = alt ? ~tfs_s : sport_tx_irq_i;
    wire per_lvl = (|tsf_q) | (|pio_flg_q);
    wire [2:0] lvl3 = {per_lvl, tx_lvl, rx_lvl};
    wire [2:0] edg3 = {ictl_q[ICTL_PER_EDGE], ictl_q[ICTL_TX_EDGE], ictl_q[ICTL_RX_EDGE]};
    wire [2:0] rise3 = lvl3 & ~edge_prev_q & edg3;
    wire [2:0] lvl_on = lvl3 & ~edg3;

    // Core pending vector; level sources show live (see RULE3) (see RULE4)
    logic [7:0] set_v, pend, en, act;
    always_comb begin
        set_v = 8'h00;
        set_v[CI_TIMER] = timer_irq_i;
        set_v[CI_RX] = rise3[0];
        set_v[CI_TX] = rise3[1];
        set_v[CI_PER] = rise3[2];
        pend = lat_q;
        pend[CI_RX] = lat_q[CI_RX] | lvl_on[0];
        pend[CI_TX] = lat_q[CI_TX] | lvl_on[1];
        pend[CI_PER] = lat_q[CI_PER] | lvl_on[2];
    end

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_mask
            assign en[g] = core_interrupt_mask_q[MASK_POS[g]];
        end
    endgenerate
    assign act = pend & en;

    // Priority select of pending and in-service (see RULE10)
    logic [2:0] best, top;
    always_comb begin
        best = 3'd0;
        top = 3'd0;
        for (int i = 0; i < 8; i++) begin
            if (act[i]) begin
                best = 3'(i);
            end
            if (isv_q[i]) begin
                top = 3'(i);
            end
        end
    end

    // Preemption only with nesting enabled (see RULE6)
    wire allowed = (isv_q == 8'h00) | (ictl_q[ICTL_NEST] & (best > top));
    assign irq_req_o = (|act) & allowed;

    // Vector slot, peripheral split by sub-source (see RULE7) (see RULE8)
    logic [5:0] per_vec;
    always_comb begin
        if (tsf_q[TSF_TRIP]) begin
            per_vec = VEC_TRIP;
        end else if (tsf_q[TSF_SYNC]) begin
            per_vec = VEC_SYNC;
        end else if (|pio_flg_q) begin
            per_vec = VEC_PIO;
        end else begin
            per_vec = VEC[CI_PER];
        end
    end
    assign irq_vector_o = (best == 3'(CI_PER)) ? per_vec : VEC[best];

    // Latched core interrupts; force wins over clear (see RULE1) (see RULE2)
    logic [7:0] lat_d, isv_d;
    always_comb begin
        lat_d = lat_q;
        isv_d = isv_q;
        if (irq_return_i && isv_q != 8'h00) begin
            isv_d[top] = 1'b0;
        end
        if (irq_take_i && irq_req_o) begin
            lat_d[best] = 1'b0;
            isv_d[best] = 1'b1;
        end
        if (wr_ifc) begin
            lat_d = (lat_d & ~wdat[7:0]) | wdat[15:IFC_FORCE];
        end
        lat_d = lat_d | set_v;
    end

    // Sticky flags; new event beats the clearing read (see RULE11) (see RULE12) (see RULE23)
    wire [1:0] tsf_d = (rd_tsf ? 2'b00 : tsf_q) | {sync_ev, trip_ev};
    wire [8:0] pio_d = (rd_pio ? 9'h000 : pio_flg_q) | pio_ev;

    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            tsf_q <= 2'b00;
            pio_flg_q <= RST_9;
            lat_q <= RST_8;
            isv_q <= RST_8;
        end else begin
            tsf_q <= tsf_d; // see RULE9
            pio_flg_q <= pio_d; // see RULE9
            lat_q <= lat_d;
            isv_q <= isv_d;
        end
    end

    // Edge history; pins sampled after sync
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            edge_prev_q <= 3'b000;
            trip_prev_q <= 1'b1;
            oc_prev_q <= 1'b0;
            sync_prev_q <= 1'b0;
            pio_prev_q <= RST_9;
        end else begin
            edge_prev_q <= lvl3;
            trip_prev_q <= trip_n_s;
            oc_prev_q <= oc_s;
            sync_prev_q <= pwm_sync_pulse_i;
            pio_prev_q <= pio_s;
        end
    end

    // Software-written registers
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            mode_q <= RST_9;
            pio_en_q <= RST_9;
            sysctl_q <= RST_16;
            core_interrupt_mask_q <= RST_16;
            ictl_q <= 5'b00000;
        end else if (wr) begin
            if (idx == IDX_MODE) begin
                mode_q <= (mode_q & ~bmask[8:0]) | (wdat[8:0] & bmask[8:0]);
            end else if (idx == IDX_PIO_EN_LO && lane[0]) begin
                pio_en_q[7:0] <= wdat[7:0];
            end else if (idx == IDX_PIO_EN_HI && lane[0]) begin
                pio_en_q[8] <= wdat[0];
            end else if (idx == IDX_SYSCTL) begin
                sysctl_q <= (sysctl_q & ~bmask) | (wdat & bmask);
            end else if (idx == IDX_CORE_INTERRUPT_MASK) begin
                core_interrupt_mask_q <= (core_interrupt_mask_q & ~bmask) | (wdat & bmask);
            end else if (idx == IDX_ICTL && lane[0]) begin
                ictl_q <= wdat[4:0];
            end
        end
    end

    // Read mux; unmapped and write-only read zero (see RULE14)
    logic [15:0] rmux;
    always_comb begin
        if (idx == IDX_PIO_EN_LO) begin
            rmux = {8'h00, pio_en_q[7:0]};
        end else if (idx == IDX_PIO_FLG_LO) begin
            rmux = {8'h00, pio_flg_q[7:0]};
        end else if (idx == IDX_MODE) begin
            rmux = {7'h00, mode_q};
        end else if (idx == IDX_SYSTEM_STATUS) begin
            rmux = {12'h000, pwm_state_i, wdog_state_i, trip_n_s};
        end else if (idx == IDX_TSF) begin
            rmux = {14'h0000, tsf_q};
        end else if (idx == IDX_PIO_EN_HI) begin
            rmux = {15'h0000, pio_en_q[8]};
        end else if (idx == IDX_PIO_FLG_HI) begin
            rmux = {15'h0000, pio_flg_q[8]};
        end else if (idx == IDX_SYSCTL) begin
            rmux = sysctl_q;
        end else if (idx == IDX_ICTL) begin
            rmux = {11'h000, ictl_q};
        end else if (idx == IDX_CORE_INTERRUPT_MASK) begin
            rmux = core_interrupt_mask_q;
        end else if (idx == IDX_IPEND) begin
            rmux = {isv_q, pend};
        end else begin
            rmux = 16'h0000;
        end
    end

    // Single-wait-state acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (rd) begin
                rdat_q <= {16'h0000, rmux};
            end
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // Held low while any flag pending (see RULE9)
    assign peripheral_interrupt_line_n_o = ~per_lvl;

    // Registered pin routing (see RULE15) (see RULE16) (see RULE17)
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            internal_receive_input_o <= 1'b0;
            internal_rfs_o <= 1'b0;
            flag_input_pin_o <= 1'b0;
            transmit_data_pin_o <= 1'b0;
            receive_frame_sync_o <= 1'b0;
            receive_frame_sync_oe_o <= 1'b0;
        end else begin
            internal_receive_input_o <= rx_sel;
            internal_rfs_o <= uart ? rx_sel : rfs_s;
            flag_input_pin_o <= alt ? rx_sel : 1'b0;
            transmit_data_pin_o <= alt ? flag_output_pin_i : sport_dt_i;
            receive_frame_sync_o <= uart ? core_output_flag_i : sport_rfs_o_i;
            receive_frame_sync_oe_o <= uart | sport_rfs_oe_i;
        end
    end

    AST_FORCE_SW: assert property (@(posedge clk_i) disable iff (rst_all) // see RULE1
        wr_ifc && wdat[12] |=> lat_q[4] || $past(irq_take_i))
        else $error("force bit did not raise software interrupt");
    AST_SW_ONLY: assert property (@(posedge clk_i) disable iff (rst_all) // see RULE2
        $rose(lat_q[3]) || $rose(lat_q[4]) |-> $past(wr_ifc))
        else $error("software interrupt without force write");
    AST_CLEAR: assert property (@(posedge clk_i) disable iff (rst_all) // see RULE1
        wr_ifc && wdat[3] && !wdat[11] |=> !lat_q[3])
        else $error("clear bit did not clear");
    AST_LEVEL: assert property (@(posedge clk_i) disable iff (rst_all) // see RULE3
        !ictl_q[ICTL_RX_EDGE] && rx_lvl |-> pend[CI_RX])
        else $error("level receive interrupt not pending");
    AST_NEST: assert property (@(posedge clk_i) disable iff (rst_all) // see RULE6
        isv_q != 8'h00 && !ictl_q[ICTL_NEST] |-> !irq_req_o)
        else $error("preemption with nesting off");
    AST_VEC: assert property (@(posedge clk_i) disable iff (rst_all) // see RULE7
        irq_req_o |-> irq_vector_o[1:0] == 2'b00 && irq_vector_o <= 6'h2C)
        else $error("vector outside table");
    AST_PLINE: assert property (@(posedge clk_i) disable iff (rst_all) // see RULE9
        $rose(tsf_q[TSF_SYNC]) |-> !peripheral_interrupt_line_n_o && $past(sync_ev))
        else $error("sync flag without cause or line");
    AST_TSF_CLR: assert property (@(posedge clk_i) disable iff (rst_all) // see RULE11
        rd_tsf && !trip_ev && !sync_ev |=> tsf_q == 2'b00)
        else $error("status read did not clear");
    AST_PIO_CLR: assert property (@(posedge clk_i) disable iff (rst_all) // see RULE12
        rd_pio && pio_ev == 9'h000 |=> pio_flg_q == 9'h000)
        else $error("pin flag read did not clear");
    AST_SETWIN: assert property (@(posedge clk_i) disable iff (rst_all) // see RULE23
        rd_tsf && (trip_ev || sync_ev) |=>
        tsf_q[TSF_TRIP] == $past(trip_ev) && tsf_q[TSF_SYNC] == $past(sync_ev))
        else $error("event lost on clearing read");
    AST_RXSEL: assert property (@(posedge clk_i) disable iff (rst_all) // see RULE15
        mode_q[MODE_RXSEL] |=> internal_receive_input_o == $past(rxb_s))
        else $error("second receive pin not routed");
    AST_UART: assert property (@(posedge clk_i) disable iff (rst_all) // see RULE17
        uart |=> receive_frame_sync_o == $past(core_output_flag_i) && receive_frame_sync_oe_o)
        else $error("frame-sync pin not driven by flag");
endmodule

/* test/pimc_seq_model.sv */
// Behavioural program sequencer that takes and returns core interrupts
module pimc_seq_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Request side
    input wire logic irq_req_i,
    input wire logic [7:0] take_delay_i,
    // Answers
    output logic irq_take_o,
    output logic irq_return_o
);
    logic busy_q;
    logic [7:0] cnt_q;

    // Service routine length is fixed; a slow take lets software cancel first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
            irq_take_o <= 1'b0;
            irq_return_o <= 1'b0;
        end else begin
            irq_take_o <= 1'b0;
            irq_return_o <= 1'b0;
            if (!busy_q) begin
                if (!irq_req_i) begin
                    cnt_q <= 8'h00;
                end else if (cnt_q == take_delay_i) begin
                    irq_take_o <= 1'b1;
                    busy_q <= 1'b1;
                    cnt_q <= 8'h00;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end else if (cnt_q == 8'h0A) begin
                irq_return_o <= 1'b1;
                busy_q <= 1'b0;
                cnt_q <= 8'h00;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule

/* test/pimc_top_tb.sv */
// Self-checking bench for the interrupt and serial mode control block
module pimc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pimc_pkg::*;
    logic clk_i, rst_i, sw_reset_i, wdog_reset_i, irq_take_i, irq_return_i;
    pimc_wb_req_t wb_q;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, irq_req_o, line_n, timer_irq_i, sport_rx_irq_i, sport_tx_irq_i;
    logic [5:0] irq_vector_o;
    logic trip_input_n_i, overcurrent_i, pwm_sync_pulse_i, wdog_state_i;
    logic [8:0] pio_pins_i;
    logic [1:0] pwm_state_i;
    logic [8:0] rnd;
    logic [7:0] take_delay;
    logic rx_in, rfs, rfs_oe, flag_in, dt_out, irfs, sel_pin;
    int bad_count = 0;
    int cmp_count = 0;

    pimc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .sw_reset_i(sw_reset_i),
        .wdog_reset_i(wdog_reset_i), .wb_i(wb_q), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .timer_irq_i(timer_irq_i), .sport_rx_irq_i(sport_rx_irq_i),
        .sport_tx_irq_i(sport_tx_irq_i), .irq_take_i(irq_take_i),
        .irq_return_i(irq_return_i), .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o),
        .trip_input_n_i(trip_input_n_i), .overcurrent_i(overcurrent_i),
        .pwm_sync_pulse_i(pwm_sync_pulse_i), .pio_pins_i(pio_pins_i),
        .wdog_state_i(wdog_state_i), .pwm_state_i(pwm_state_i),
        .peripheral_interrupt_line_n_o(line_n), .receive_pin_first_i(rnd[0]),
        .receive_pin_second_i(rnd[1]), .receive_frame_sync_i(rnd[4]),
        .transmit_frame_sync_i(rnd[5]), .sport_dt_i(rnd[6]), .sport_rfs_o_i(rnd[7]),
        .sport_rfs_oe_i(rnd[8]), .core_output_flag_i(rnd[2]), .flag_output_pin_i(rnd[3]),
        .internal_receive_input_o(rx_in), .internal_rfs_o(irfs), .flag_input_pin_o(flag_in),
        .transmit_data_pin_o(dt_out), .receive_frame_sync_o(rfs),
        .receive_frame_sync_oe_o(rfs_oe));

    pimc_seq_model seq_u (.clk_i(clk_i), .rst_i(rst_i), .irq_req_i(irq_req_o),
        .take_delay_i(take_delay), .irq_take_o(irq_take_i), .irq_return_o(irq_return_i));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Receive pin that the select bit should route
    function automatic logic pick(input logic sel, input logic [8:0] r);
        return sel ? r[1] : r[0];
    endfunction

    task automatic bus(input logic we, input logic [15:0] idx, input logic [15:0] wd,
        output logic [31:0] rdat);
        @(posedge clk_i);
        wb_q <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h3, adr: {idx, 2'b00},
            dat: {16'h0000, wd}};
        // A missing ack is left to the watchdog
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_q <= '0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, d);
    endtask

    task automatic rd_chk(input string nm, input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 16'h0000, d);
        chk(nm, d, exp);
    endtask

    // Combinational request is sampled mid-cycle to stay clear of edge updates
    task automatic wait_req(input logic lvl);
        int n;
        n = 0;
        while (irq_req_o !== lvl && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 100) begin
            bad_count++;
            finish_test();
        end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    initial begin
        #500000;
        bad_count++;
        finish_test();
    end

    initial begin
        {rst_i, sw_reset_i, wdog_reset_i, timer_irq_i, sport_rx_irq_i} = 5'b10000;
        {sport_tx_irq_i, overcurrent_i, pwm_sync_pulse_i, wdog_state_i} = 4'h0;
        trip_input_n_i = 1'b1;
        pio_pins_i = 9'h000;
        pwm_state_i = 2'b00;
        rnd = 9'h000;
        take_delay = 8'h00;
        wb_q = '0;
        void'($urandom(74074));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("mode_reset", IDX_MODE, 32'h0);
        rd_chk("unmapped", 16'h2014, 32'h0);
        wdog_state_i <= 1'b1;
        pwm_state_i <= 2'b10;
        repeat (4) @(posedge clk_i);
        rd_chk("sys_status", IDX_SYSTEM_STATUS, 32'hB);
        // Every combination of receive select, UART mode and alternate config
        for (int i = 0; i < 16; i++) begin
            wr(IDX_MODE, {10'h000, i[1], i[0], 4'h0});
            wr(IDX_SYSCTL, {5'h00, i[2], 10'h000});
            rnd <= 9'($urandom);
            repeat (6) @(posedge clk_i);
            sel_pin = pick(i[0], rnd);
            if (!i[1]) chk("rfs_pass", {rfs_oe, rfs}, {rnd[8], rnd[7]});
            if (!i[2]) chk("dt_pass", {flag_in, dt_out}, {1'b0, rnd[6]});
            if (!i[2]) chk("rx_in", rx_in, sel_pin);
            if (i[1] && !i[2]) chk("rfs_tie", irfs, sel_pin);
            if (i[1]) chk("rfs_pin", {rfs_oe, rfs}, {1'b1, rnd[2]});
            if (i[2]) chk("flag_in", flag_in, sel_pin);
            if (i[2]) chk("flag_out", dt_out, rnd[3]);
        end
        wr(IDX_SYSCTL, 16'h0000);
        // Software write, pin fall and overcurrent each trip
        for (int k = 0; k < 3; k++) begin
            if (k == 0) wr(IDX_SWTRIP, 16'h0001);
            if (k == 1) trip_input_n_i <= 1'b0;
            if (k == 2) overcurrent_i <= 1'b1;
            repeat (6) @(posedge clk_i);
            chk("line_trip", line_n, 1'b0);
            rd_chk("tsf_trip", IDX_TSF, 32'h1);
            rd_chk("tsf_clear", IDX_TSF, 32'h0);
            chk("line_idle", line_n, 1'b1);
            trip_input_n_i <= 1'b1;
            overcurrent_i <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
        pwm_sync_pulse_i <= 1'b1;
        @(posedge clk_i);
        pwm_sync_pulse_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        // Second pulse lands in the cycle the clearing read is taken
        fork
            rd_chk("tsf_sync", IDX_TSF, 32'h2);
            begin
                @(posedge clk_i);
                pwm_sync_pulse_i <= 1'b1;
                @(posedge clk_i);
                pwm_sync_pulse_i <= 1'b0;
            end
        join
        rd_chk("tsf_keep", IDX_TSF, 32'h2);
        // Pin change on both flag registers, one read clears both
        wr(IDX_PIO_EN_LO, 16'h0001);
        wr(IDX_PIO_EN_HI, 16'h0001);
        pio_pins_i <= 9'h101;
        repeat (6) @(posedge clk_i);
        chk("line_pio", line_n, 1'b0);
        rd_chk("pio_lo", IDX_PIO_FLG_LO, 32'h1);
        rd_chk("pio_hi", IDX_PIO_FLG_HI, 32'h0);
        chk("line_pio_idle", line_n, 1'b1);
        wr(IDX_ICTL, 16'h0000);
        wr(IDX_CORE_INTERRUPT_MASK, 16'h0206);
        wr(IDX_IFC, 16'h1800);
        wait_req(1'b1);
        chk("vec_sw1", irq_vector_o, 6'h18);
        wait_req(1'b0);
        wait_req(1'b1);
        chk("vec_sw0", irq_vector_o, 6'h1C);
        wait_req(1'b0);
        take_delay <= 8'h14;
        wr(IDX_IFC, 16'h0800);
        // Clear only once the request shows, well before the slow take
        wait_req(1'b1);
        wr(IDX_IFC, 16'h0008);
        repeat (3) @(negedge clk_i);
        chk("cleared", irq_req_o, 1'b0);
        // Receive source edge sensed, then level, then from frame-sync pins
        wr(IDX_ICTL, 16'h0001);
        wr(IDX_CORE_INTERRUPT_MASK, 16'h0008);
        sport_rx_irq_i <= 1'b1;
        wait_req(1'b1);
        chk("vec_rx", irq_vector_o, 6'h24);
        wait_req(1'b0);
        repeat (20) @(posedge clk_i);
        rd_chk("rx_edge_once", IDX_IPEND, 32'h0000);
        take_delay <= 8'hFF;
        wr(IDX_ICTL, 16'h0000);
        rd_chk("rx_level", IDX_IPEND, 32'h0002);
        sport_rx_irq_i <= 1'b0;
        rnd <= 9'h030;
        wr(IDX_SYSCTL, 16'h0400);
        rd_chk("alt_idle", IDX_IPEND, 32'h0000);
        rnd <= 9'h020;
        repeat (3) @(posedge clk_i);
        rd_chk("alt_rx", IDX_IPEND, 32'h0002);
        rnd <= 9'h010;
        repeat (3) @(posedge clk_i);
        rd_chk("alt_tx", IDX_IPEND, 32'h0004);
        // Software and watchdog resets both restore the mode register
        for (int k = 0; k < 2; k++) begin
            wr(IDX_MODE, 16'h01FF);
            if (k == 0) sw_reset_i <= 1'b1;
            else wdog_reset_i <= 1'b1;
            @(posedge clk_i);
            {sw_reset_i, wdog_reset_i} <= 2'b00;
            rd_chk("mode_swrst", IDX_MODE, 32'h0);
        end
        finish_test();
    end
endmodule
